// *** hdl/csl_pkg.sv ***
// Constants, field layout and state codes for the context save link unit.
// Assumes one 100 MHz clock, APB register access and a word-wide data memory.
//
// Functional notes
// - A call stores the whole old link word as the new area's first word.
// - Begin-ISR stores the whole old link word into its allocated area.
// - Lower save stores the whole old link word into its allocated area.
// - Return reloads every link field from the area being released.
// - Return-from-exception reloads every link field from the released area.
// - After the store, saves update priority, enable, upper/lower, segment, offset.
// - Lower restore reloads the entire link word, not just pointer fields.
// - Lower saves first flush any cached upper context to memory.
// - No sync step needed: lower save completes only after memory holds it.
// - Link word readable at core register address fe00 before begin-ISR.
// - After begin-ISR, old priority sits in bits 31:24 of the new link word.
package csl_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_LINK = 8'h04;
    localparam logic [7:0] OFF_FREE = 8'h08;
    localparam logic [7:0] OFF_PRIO = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;

    // Command word layout
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 3;
    localparam int CMD_PRI_LSB = 8;

    // Operation codes
    localparam logic [2:0] OP_CALL = 3'h1;
    localparam logic [2:0] OP_RET = 3'h2;
    localparam logic [2:0] OP_BEGIN_ISR = 3'h3;
    localparam logic [2:0] OP_SAVE_LOWER = 3'h4;
    localparam logic [2:0] OP_RESTORE_LOWER = 3'h5;
    localparam logic [2:0] OP_RETURN_EXC = 3'h6;

    // Link word layout
    localparam int PRI_W = 8;
    localparam int LNK_PRIOR_PRIORITY_NUMBER_LSB = 24;
    localparam int LNK_PIE_BIT = 23;
    localparam int LNK_UL_BIT = 22;
    localparam int LNK_SEG_LSB = 16;
    localparam int LNK_SEG_W = 4;
    localparam int LNK_OFF_W = 16;
    localparam logic [31:0] LNK_PTR_MASK = 32'h000f_ffff;
    localparam logic [31:0] LINK_RESET = 32'h0000_0000;

    // Priority register layout: bit 8 enable, bits 7:0 current priority
    localparam int PRIO_IE_BIT = 8;

    // Status bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_ERR = 2;
    localparam int STAT_CACHED = 3;

    // Context area geometry
    localparam logic [3:0] CSA_FIRST = 4'h0;
    localparam logic [3:0] CSA_SECOND = 4'h1;
    localparam logic [3:0] CSA_LAST = 4'hf;
    localparam logic [5:0] CSA_SHIFT_ZERO = 6'h00;

    // Core register address of the link word
    localparam logic [15:0] CORE_REG_LINK = 16'hfe00;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FLUSH = 6'h02,
        ST_FETCH = 6'h04,
        ST_SAVE = 6'h08,
        ST_LOAD = 6'h10,
        ST_RELEASE = 6'h20
    } csl_state_t;

endpackage

// *** hdl/csl_mem_burst.sv ***
// Word burst engine toward the data memory holding the context areas.
// Assumes memory holds req, we, addr, wdata until it answers with ack.
`timescale 1ns/100ps
module csl_mem_burst (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_we,
    input wire logic [31:0] i_base,
    input wire logic [3:0] i_first,
    input wire logic [3:0] i_last,
    input wire logic [31:0] i_wdata,
    output logic [3:0] o_idx,
    output logic o_busy,
    output logic o_done,
    output logic o_rvalid,
    output logic [3:0] o_ridx,
    output logic [31:0] o_rdata,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata
);
    logic active, we, done, rvalid;
    logic [31:0] base, wdata, rdata;
    logic [3:0] idx, last, ridx;
    logic next_active, next_we, next_done, next_rvalid;
    logic [31:0] next_base, next_rdata;
    logic [3:0] next_idx, next_last, next_ridx;

    ////////////////////////////////////////////////////////////////////////
    // Next word; wdata follows the index so it is ready in the same cycle as the request
    always_comb begin
        next_active = active;
        next_we = we;
        next_base = base;
        next_idx = idx;
        next_last = last;
        next_done = 1'b0;
        next_rvalid = 1'b0;
        next_rdata = rdata;
        next_ridx = ridx;
        if (!active && i_start) begin
            next_active = 1'b1;
            next_we = i_we;
            next_base = i_base;
            next_idx = i_first;
            next_last = i_last;
        end else if (active && i_mem_ack) begin
            next_rvalid = !we;
            next_rdata = i_mem_rdata;
            next_ridx = idx;
            if (idx == last) begin
                next_active = 1'b0;
                next_done = 1'b1;
            end else begin
                next_idx = idx + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            active <= 1'b0;
            we <= 1'b0;
            base <= '0;
            idx <= '0;
            last <= '0;
            done <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            ridx <= '0;
            wdata <= '0;
        end else begin
            active <= next_active;
            we <= next_we;
            base <= next_base;
            idx <= next_idx;
            last <= next_last;
            done <= next_done;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            ridx <= next_ridx;
            wdata <= i_wdata;
        end
    end

    // Word address: base plus four bytes per word
    assign o_idx = next_idx;
    assign o_busy = active;
    assign o_done = done;
    assign o_rvalid = rvalid;
    assign o_ridx = ridx;
    assign o_rdata = rdata;
    assign o_mem_req = active;
    assign o_mem_we = we;
    assign o_mem_addr = base + {26'h0, idx, 2'h0};
    assign o_mem_wdata = wdata;

endmodule // csl_mem_burst

// *** hdl/csl_context_link.sv ***
// Context save/restore link unit: keeps the link word, free list head and
// current priority, and moves context areas to and from data memory.
// Assumes APB master on i_clock and a memory answering through csl_mem_burst.
`timescale 1ns/100ps
module csl_context_link (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [15:0] i_cr_addr,
    output logic [31:0] o_cr_data,
    output logic [3:0] o_ctx_idx,
    output logic o_ctx_upper,
    input wire logic [31:0] i_ctx_word,
    output logic o_ctx_rvalid,
    output logic [3:0] o_ctx_ridx,
    output logic [31:0] o_ctx_rdata,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata
);
    csl_pkg::csl_state_t state, next_state;
    logic [31:0] link, free_ptr, alloc, loaded, cache_base, prdata, cr_data;
    logic [31:0] next_link, next_free, next_alloc, next_loaded, next_cache_base, next_prdata;
    logic [8:0] prio, next_prio;
    logic [2:0] op, next_op;
    logic [7:0] operand, next_operand;
    logic cache_pend, done, err, next_cache_pend, next_done, next_err;
    logic b_start, b_we, b_busy, b_done, b_rvalid;
    logic [31:0] b_base, b_wdata, b_rdata;
    logic [3:0] b_first, b_last, b_idx, b_ridx;
    logic wr_acc, rd_setup, cmd_wr, cmd_bad, mapped;

    // Byte address of a context area from a link or free pointer word
    function automatic logic [31:0] area_addr(input logic [31:0] w);
        area_addr = {w[csl_pkg::LNK_SEG_LSB +: csl_pkg::LNK_SEG_W], csl_pkg::CSA_SHIFT_ZERO,
                     w[csl_pkg::LNK_OFF_W-1:0], csl_pkg::CSA_SHIFT_ZERO};
    endfunction

    function automatic logic is_lower_save(input logic [2:0] o);
        is_lower_save = (o == csl_pkg::OP_BEGIN_ISR) || (o == csl_pkg::OP_SAVE_LOWER);
    endfunction

    function automatic logic is_save(input logic [2:0] o);
        is_save = (o == csl_pkg::OP_CALL) || is_lower_save(o);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, read data latched in the setup cycle
    always_comb begin
        mapped = (i_paddr == csl_pkg::OFF_CMD) || (i_paddr == csl_pkg::OFF_LINK) ||
                 (i_paddr == csl_pkg::OFF_FREE) || (i_paddr == csl_pkg::OFF_PRIO) ||
                 (i_paddr == csl_pkg::OFF_STAT);
        wr_acc = i_psel && i_penable && i_pwrite;
        rd_setup = i_psel && !i_penable && !i_pwrite;
        cmd_wr = wr_acc && (i_paddr == csl_pkg::OFF_CMD);
        // Commands or state writes while busy would tear an operation
        cmd_bad = wr_acc && (state != csl_pkg::ST_IDLE) && (i_paddr != csl_pkg::OFF_STAT);
        next_prdata = prdata;
        if (rd_setup) begin
            case (i_paddr)
                csl_pkg::OFF_LINK: next_prdata = link;
                csl_pkg::OFF_FREE: next_prdata = free_ptr;
                csl_pkg::OFF_PRIO: next_prdata = {23'h0, prio};
                csl_pkg::OFF_STAT: next_prdata = {28'h0, cache_pend, err, done,
                                                  state != csl_pkg::ST_IDLE};
                default: next_prdata = '0;
            endcase
        end
    end

    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && (!mapped || cmd_bad);
    assign o_prdata = prdata;

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    always_comb begin
        next_state = state;
        next_link = link;
        next_free = free_ptr;
        next_alloc = alloc;
        next_loaded = loaded;
        next_cache_base = cache_base;
        next_cache_pend = cache_pend;
        next_prio = prio;
        next_op = op;
        next_operand = operand;
        next_done = done;
        next_err = err;
        b_start = 1'b0;
        b_we = 1'b0;
        b_base = '0;
        b_first = csl_pkg::CSA_FIRST;
        b_last = csl_pkg::CSA_FIRST;
        // Software clears sticky bits; a set in the same cycle wins below
        if (wr_acc && i_paddr == csl_pkg::OFF_STAT) begin
            next_done = done && !i_pwdata[csl_pkg::STAT_DONE];
            next_err = err && !i_pwdata[csl_pkg::STAT_ERR];
        end
        case (state)
            csl_pkg::ST_IDLE: begin
                if (wr_acc && i_paddr == csl_pkg::OFF_LINK) next_link = i_pwdata;
                if (wr_acc && i_paddr == csl_pkg::OFF_FREE) next_free = i_pwdata;
                if (wr_acc && i_paddr == csl_pkg::OFF_PRIO) next_prio = i_pwdata[8:0];
                if (cmd_wr) begin
                    next_op = i_pwdata[csl_pkg::CMD_OP_LSB +: csl_pkg::CMD_OP_W];
                    next_operand = i_pwdata[csl_pkg::CMD_PRI_LSB +: csl_pkg::PRI_W];
                    if (cache_pend) begin
                        // Upper words of the last call still held back; write them first
                        next_state = csl_pkg::ST_FLUSH;
                        b_start = 1'b1;
                        b_we = 1'b1;
                        b_base = cache_base;
                        b_first = csl_pkg::CSA_SECOND;
                        b_last = csl_pkg::CSA_LAST;
                    end else begin
                        next_state = csl_pkg::ST_FETCH;
                    end
                end
            end
            csl_pkg::ST_FLUSH: begin
                if (b_done) begin
                    next_cache_pend = 1'b0;
                    next_state = csl_pkg::ST_FETCH;
                end
            end
            csl_pkg::ST_FETCH: begin
                // Dispatch; save ops pop the free list, restores read the linked area
                if (is_save(op)) begin
                    if (!b_busy && !b_done) begin
                        if ((free_ptr & csl_pkg::LNK_PTR_MASK) == '0) begin
                            next_err = 1'b1;
                            next_state = csl_pkg::ST_IDLE;
                        end else begin
                            next_alloc = free_ptr;
                            b_start = 1'b1;
                            b_base = area_addr(free_ptr);
                        end
                    end
                    if (b_rvalid) next_free = b_rdata;
                    if (b_done) begin
                        next_state = csl_pkg::ST_SAVE;
                        b_start = 1'b1;
                        b_we = 1'b1;
                        b_base = area_addr(alloc);
                        // Call writes only the link word now and caches the rest
                        b_last = (op == csl_pkg::OP_CALL) ? csl_pkg::CSA_FIRST : csl_pkg::CSA_LAST;
                    end
                end else if (op == csl_pkg::OP_RET || op == csl_pkg::OP_RETURN_EXC ||
                             op == csl_pkg::OP_RESTORE_LOWER) begin
                    if ((link & csl_pkg::LNK_PTR_MASK) == '0) begin
                        next_err = 1'b1;
                        next_state = csl_pkg::ST_IDLE;
                    end else begin
                        next_state = csl_pkg::ST_LOAD;
                        b_start = 1'b1;
                        b_base = area_addr(link);
                        b_last = csl_pkg::CSA_LAST;
                    end
                end else begin
                    next_err = 1'b1;
                    next_state = csl_pkg::ST_IDLE;
                end
            end
            csl_pkg::ST_SAVE: begin
                // Link stays put until the old-link store has completed
                if (b_done) begin
                    next_link = '0;
                    next_link[csl_pkg::LNK_PRIOR_PRIORITY_NUMBER_LSB +: csl_pkg::PRI_W] = prio[7:0];
                    next_link[csl_pkg::LNK_PIE_BIT] = prio[csl_pkg::PRIO_IE_BIT];
                    next_link[csl_pkg::LNK_UL_BIT] = (op == csl_pkg::OP_CALL);
                    next_link[19:0] = alloc[19:0];
                    if (op == csl_pkg::OP_CALL) begin
                        next_cache_pend = 1'b1;
                        next_cache_base = area_addr(alloc);
                    end
                    if (op == csl_pkg::OP_BEGIN_ISR) next_prio = {1'b1, operand};
                    next_done = 1'b1;
                    next_state = csl_pkg::ST_IDLE;
                end
            end
            csl_pkg::ST_LOAD: begin
                if (b_rvalid && b_ridx == csl_pkg::CSA_FIRST) next_loaded = b_rdata;
                if (b_done) begin
                    // Give the area back: its first word becomes the old free head
                    next_state = csl_pkg::ST_RELEASE;
                    b_start = 1'b1;
                    b_we = 1'b1;
                    b_base = area_addr(link);
                end
            end
            csl_pkg::ST_RELEASE: begin
                if (b_done) begin
                    next_free = link & csl_pkg::LNK_PTR_MASK;
                    next_link = loaded;
                    if (op == csl_pkg::OP_RETURN_EXC) begin
                        next_prio = {loaded[csl_pkg::LNK_PIE_BIT],
                                     loaded[csl_pkg::LNK_PRIOR_PRIORITY_NUMBER_LSB +: csl_pkg::PRI_W]};
                    end
                    next_done = 1'b1;
                    next_state = csl_pkg::ST_IDLE;
                end
            end
            default: next_state = csl_pkg::ST_IDLE;
        endcase
    end

    // Store data apart from the sequencer, which drives the index it reads
    always_comb begin
        // First word of a save is the whole old link, else a context word
        if (b_idx == csl_pkg::CSA_FIRST) begin
            b_wdata = (next_state == csl_pkg::ST_RELEASE) ? free_ptr : link;
        end else begin
            b_wdata = i_ctx_word;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= csl_pkg::ST_IDLE;
            link <= csl_pkg::LINK_RESET;
            free_ptr <= '0;
            alloc <= '0;
            loaded <= '0;
            cache_base <= '0;
            cache_pend <= 1'b0;
            prio <= '0;
            op <= '0;
            operand <= '0;
            done <= 1'b0;
            err <= 1'b0;
            prdata <= '0;
            cr_data <= '0;
        end else begin
            state <= next_state;
            link <= next_link;
            free_ptr <= next_free;
            alloc <= next_alloc;
            loaded <= next_loaded;
            cache_base <= next_cache_base;
            cache_pend <= next_cache_pend;
            prio <= next_prio;
            op <= next_op;
            operand <= next_operand;
            done <= next_done;
            err <= next_err;
            prdata <= next_prdata;
            cr_data <= (i_cr_addr == csl_pkg::CORE_REG_LINK) ? link : '0;
        end
    end

    assign o_cr_data = cr_data;
    assign o_ctx_idx = b_idx;
    assign o_ctx_upper = (state == csl_pkg::ST_FLUSH) || (op == csl_pkg::OP_CALL) ||
                         (op == csl_pkg::OP_RET) || (op == csl_pkg::OP_RETURN_EXC);
    assign o_ctx_rvalid = b_rvalid && (state == csl_pkg::ST_LOAD);
    assign o_ctx_ridx = b_ridx;
    assign o_ctx_rdata = b_rdata;

    csl_mem_burst u_burst (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_start(b_start),
        .i_we(b_we),
        .i_base(b_base),
        .i_first(b_first),
        .i_last(b_last),
        .i_wdata(b_wdata),
        .o_idx(b_idx),
        .o_busy(b_busy),
        .o_done(b_done),
        .o_rvalid(b_rvalid),
        .o_ridx(b_ridx),
        .o_rdata(b_rdata),
        .o_mem_req(o_mem_req),
        .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata),
        .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_call_old_link: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_SAVE && op == csl_pkg::OP_CALL && o_mem_req &&
         o_mem_addr == area_addr(alloc)) |-> (o_mem_we && o_mem_wdata == link))
        else $error("call did not store old link");
    a_isr_old_link: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_SAVE && op == csl_pkg::OP_BEGIN_ISR && o_mem_req &&
         o_mem_addr == area_addr(alloc)) |-> o_mem_wdata == link)
        else $error("begin isr did not store old link");
    a_lower_old_link: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_SAVE && op == csl_pkg::OP_SAVE_LOWER && o_mem_req &&
         o_mem_addr == area_addr(alloc)) |-> o_mem_wdata == link)
        else $error("lower save did not store old link");
    a_ret_reload: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_RELEASE && b_done && op == csl_pkg::OP_RET) |=> link == $past(loaded))
        else $error("return did not reload link");
    a_rfe_reload: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_RELEASE && b_done && op == csl_pkg::OP_RETURN_EXC)
        |=> (link == $past(loaded) && prio[7:0] == link[31:24]))
        else $error("exception return did not reload link");
    a_rsl_reload: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_RELEASE && b_done && op == csl_pkg::OP_RESTORE_LOWER)
        |=> link == $past(loaded))
        else $error("lower restore did not reload full link");
    a_save_update: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_SAVE && b_done) |=> (link[19:0] == $past(alloc[19:0]) &&
        link[31:24] == $past(prio[7:0]) &&
        link[csl_pkg::LNK_PIE_BIT] == $past(prio[csl_pkg::PRIO_IE_BIT]) &&
        link[csl_pkg::LNK_UL_BIT] == (op == csl_pkg::OP_CALL)))
        else $error("link fields not updated after save");
    a_link_held: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_SAVE && !b_done) |=> $stable(link))
        else $error("link changed before old link stored");
    a_flush_first: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == csl_pkg::ST_SAVE && is_lower_save(op)) |-> !cache_pend)
        else $error("lower save with upper context still cached");
    a_core_read: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_cr_addr == csl_pkg::CORE_REG_LINK) |=> o_cr_data == $past(link))
        else $error("core register read of link wrong");

endmodule // csl_context_link

// *** bench/csl_mem_model.sv ***
// Data memory model holding the context areas, one word per slot.
// Assumes req, we, addr and wdata stand until ack; slow mode stalls.
`timescale 1ns/100ps
module csl_mem_model (
    input wire logic i_clock,
    input wire logic i_slow,
    input wire logic i_mem_req,
    input wire logic i_mem_we,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata
);
    logic [31:0] mem [0:255];
    logic [1:0] wait_cnt = 2'h0;
    logic [31:0] noise = 32'h0;
    // Slot from low offset bits and word index; small areas only
    logic [7:0] slot;
    assign slot = {i_mem_addr[9:6], i_mem_addr[5:2]};
    // Ack at once, or after two stalled cycles in slow mode
    assign o_mem_ack = i_mem_req && (!i_slow || wait_cnt == 2'h2);
    // Data only with a read ack; otherwise a pattern that never sits still
    assign o_mem_rdata = (o_mem_ack && !i_mem_we) ? mem[slot] : ~noise;
    // Stall counter and word store
    always_ff @(posedge i_clock) begin
        noise <= noise + 32'h1;
        wait_cnt <= (i_mem_req && !o_mem_ack) ? wait_cnt + 2'h1 : 2'h0;
        if (o_mem_ack && i_mem_we) begin
            mem[slot] <= i_mem_wdata;
        end
    end
endmodule // csl_mem_model

// *** bench/csl_context_link_tb.sv ***
// Bench for the context link unit: APB tasks and save/restore sequences.
// Assumes csl_mem_model as the data memory, areas at offsets 1..3.
`timescale 1ns/100ps
module csl_context_link_tb;
    logic i_clock, i_rst, psel, pen, pwr, slow, ack, req, we, err, up, crv;
    logic [7:0] pa;
    logic [15:0] cra;
    logic [3:0] ix, cri, crx;
    logic [31:0] pwd, prd, rd, crd, ma, mwd, mrd, crdw, crw;
    int n_mismatch = 0;
    int compares = 0;
    csl_context_link dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(),
        .o_pslverr(err), .i_cr_addr(cra), .o_cr_data(crd), .o_ctx_idx(ix),
        .o_ctx_upper(up), .i_ctx_word({24'hc0de00, 3'h0, up, ix}), .o_ctx_rvalid(crv),
        .o_ctx_ridx(cri), .o_ctx_rdata(crdw), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma),
        .o_mem_wdata(mwd), .i_mem_ack(ack), .i_mem_rdata(mrd));
    csl_mem_model u_mem (.i_clock(i_clock), .i_slow(slow), .i_mem_req(req), .i_mem_we(we),
        .i_mem_addr(ma), .i_mem_wdata(mwd), .o_mem_ack(ack), .o_mem_rdata(mrd));
    // Last restored context word and its index
    always @(posedge i_clock) if (crv) {crx, crw} <= {cri, crdw};
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string s, input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask
    // Setup then access; request held until pready seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge i_clock);
        pen <= 1'b1;
        do @(posedge i_clock); while (dut.o_pready !== 1'b1);
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clock);
    endtask
    // Issue one operation, poll busy with a bound, then clear done
    task op(input logic [2:0] c, input logic [7:0] p);
        int n;
        n = 0;
        apb(1'b1, csl_pkg::OFF_CMD, {16'h0000, p, 5'h00, c});
        do begin
            apb(1'b0, csl_pkg::OFF_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
        chk("status", {29'h0, rd[2:0]}, 32'h2);
        apb(1'b1, csl_pkg::OFF_STAT, 32'h6);
    endtask
    task rdchk(input string s, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(s, rd, x);
    endtask
    task complete_run;
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // Hang guard at 20000 cycles, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    // Main sequence: call, begin-isr, lower save, lower restore, exception return, return
    initial begin
        {i_rst, psel, pen, pwr, slow, pa, pwd, cra} = {1'b1, 4'h0, 8'h00, 32'h0, 16'h0};
        u_mem.mem[8'h10] = 32'h0001_0002;
        u_mem.mem[8'h20] = 32'h0001_0003;
        u_mem.mem[8'h30] = 32'h0001_0004;
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rdchk("link reset", csl_pkg::OFF_LINK, csl_pkg::LINK_RESET);
        psel <= 1'b1;
        pa <= 8'h14;
        @(posedge i_clock);
        pen <= 1'b1;
        @(posedge i_clock);
        chk("unmapped error", {31'h0, err}, 32'h1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clock);
        apb(1'b1, csl_pkg::OFF_LINK, 32'h7e80_0000);
        apb(1'b1, csl_pkg::OFF_FREE, 32'h0001_0001);
        apb(1'b1, csl_pkg::OFF_PRIO, 32'h0000_0133);
        cra <= csl_pkg::CORE_REG_LINK;
        repeat (2) @(posedge i_clock);
        chk("core read", crd, 32'h7e80_0000);
        op(csl_pkg::OP_CALL, 8'h00);
        chk("call word0", u_mem.mem[8'h10], 32'h7e80_0000);
        rdchk("link call", csl_pkg::OFF_LINK, 32'h33c1_0001);
        slow <= 1'b1;
        op(csl_pkg::OP_BEGIN_ISR, 8'h44);
        chk("flush upper", u_mem.mem[8'h11], 32'hc0de_0011);
        chk("isr word1", u_mem.mem[8'h21], 32'hc0de_0001);
        chk("isr word0", u_mem.mem[8'h20], 32'h33c1_0001);
        chk("isr prior", {24'h0, u_mem.mem[8'h20][31:24]}, 32'h33);
        rdchk("link isr", csl_pkg::OFF_LINK, 32'h3381_0002);
        rdchk("prio isr", csl_pkg::OFF_PRIO, 32'h0000_0144);
        op(csl_pkg::OP_SAVE_LOWER, 8'h00);
        chk("lower word0", u_mem.mem[8'h30], 32'h3381_0002);
        rdchk("link lower", csl_pkg::OFF_LINK, 32'h4481_0003);
        op(csl_pkg::OP_RESTORE_LOWER, 8'h00);
        rdchk("link restore", csl_pkg::OFF_LINK, 32'h3381_0002);
        chk("restored word", crw, 32'hc0de_000f);
        chk("restored index", {28'h0, crx}, 32'h0000_000f);
        slow <= 1'b0;
        op(csl_pkg::OP_RETURN_EXC, 8'h00);
        rdchk("link rfe", csl_pkg::OFF_LINK, 32'h33c1_0001);
        rdchk("prio rfe", csl_pkg::OFF_PRIO, 32'h0000_0133);
        op(csl_pkg::OP_RET, 8'h00);
        rdchk("link ret", csl_pkg::OFF_LINK, 32'h7e80_0000);
        apb(1'b1, csl_pkg::OFF_CMD, 32'h0000_0007);
        rdchk("bad op", csl_pkg::OFF_STAT, 32'h0000_0004);
        apb(1'b1, csl_pkg::OFF_STAT, 32'h6);
        complete_run();
    end
endmodule // csl_context_link_tb
